// >>> src/spimsc_pkg.sv
package spimsc_pkg;
    // two independent controllers side by side
    localparam int unsigned NCH         = 2;
    // byte width of one transfer
    localparam int unsigned DW          = 8;
    // width of the clock counter value
    localparam int unsigned CNT_W       = 8;
    // fewest clock cycles per serial bit in master mode
    localparam int unsigned MIN_BIT_CYC = 8;
    // edges of the serial clock in one byte
    localparam int unsigned EDGES       = 2 * DW;
    // receive stream buffer depth (fixed skid structure)
    localparam int unsigned BUF_DEPTH   = 2;
    localparam logic [3:0]  LAST_EDGE   = 4'(EDGES - 1);
    localparam logic [2:0]  LAST_BIT    = 3'(DW - 1);
    localparam logic [CNT_W-1:0] MIN_CNT = CNT_W'(MIN_BIT_CYC);
    // reset values
    localparam logic [DW-1:0] RST_BYTE  = 8'h00;
    localparam logic [CNT_W-1:0] RST_DIV = 8'h00;

    // master sequencer states, gray along idle -> wait -> run
    typedef enum logic [1:0] {
        SPIMSC_M_IDLE = 2'b00,
        SPIMSC_M_WAIT = 2'b01,
        SPIMSC_M_RUN  = 2'b11
    } spimsc_mst_t;

    // serial clock half period in system cycles, never below the floor
    function automatic logic [CNT_W-1:0] spimsc_half(input logic [CNT_W-1:0] cnt);
        logic [CNT_W-1:0] c;
        c = (cnt < MIN_CNT) ? MIN_CNT : cnt;
        return c >> 1;
    endfunction
endpackage

// >>> src/spimsc_top.sv
`timescale 1ns/1ns
`default_nettype none

module spimsc_top
    import spimsc_pkg::*;
(
    input  wire logic                      clk_in,
    input  wire logic                      srst_in,
    input  wire logic [NCH-1:0]            master_mode_in,
    input  wire logic [NCH-1:0]            cpol_in,
    input  wire logic [NCH-1:0]            cpha_in,
    input  wire logic [NCH-1:0][CNT_W-1:0] clk_count_in,
    input  wire logic [NCH-1:0]            data_wr_in,
    input  wire logic [NCH-1:0][DW-1:0]    data_wdata_in,
    input  wire logic [NCH-1:0]            data_rd_in,
    input  wire logic [NCH-1:0]            status_rd_in,
    output logic      [NCH-1:0][DW-1:0]    rd_data_out,
    output logic      [NCH-1:0]            transfer_done_flag_out,
    output logic      [NCH-1:0]            read_overrun_flag_out,
    output logic      [NCH-1:0]            write_collision_flag_out,
    output logic      [NCH-1:0]            mode_fault_flag_out,
    output logic      [NCH-1:0]            slave_abort_flag_out,
    output logic      [NCH-1:0]            is_master_out,
    output logic      [NCH-1:0]            rx_valid_out,
    output logic      [NCH-1:0][DW-1:0]    rx_data_out,
    input  wire logic [NCH-1:0]            rx_ready_in,
    input  wire logic [NCH-1:0]            sck_in,
    output logic      [NCH-1:0]            sck_out,
    output logic      [NCH-1:0]            sck_oe_out,
    input  wire logic [NCH-1:0]            ssel_n_in,
    input  wire logic [NCH-1:0]            mosi_in,
    output logic      [NCH-1:0]            mosi_out,
    output logic      [NCH-1:0]            mosi_oe_out,
    input  wire logic [NCH-1:0]            miso_in,
    output logic      [NCH-1:0]            miso_out,
    output logic      [NCH-1:0]            miso_oe_out
);

    // one full controller per channel, no shared state
    for (genvar c = 0; c < NCH; c++) begin : g_ch
        logic [2:0]       sck_s_q;
        logic [2:0]       sel_s_q;
        logic [1:0]       mosi_s_q;
        logic [1:0]       miso_s_q;
        logic             master_q, master_d;
        logic             mode_prev_q;
        spimsc_mst_t      mst_q, mst_d;
        logic [CNT_W-1:0] div_q, div_d;
        logic [3:0]       ecnt_q, ecnt_d;
        logic             busy_q, busy_d;
        logic             sck_q, sck_d;
        logic [DW-1:0]    sh_q, sh_d;
        logic             dout_q, dout_d;
        logic [DW-1:0]    rbuf_q, rbuf_d;
        logic             done_q, done_d;
        logic             seen_q, seen_d;
        logic             win_q, win_d;
        logic             read_overrun_flag_q, read_overrun_flag_d;
        logic             write_collision_flag_q, write_collision_flag_d;
        logic             mode_fault_flag_q, mode_fault_flag_d;
        logic             slave_abort_flag_q, slave_abort_flag_d;
        logic             sck_oe_q, sck_oe_d;
        logic             mosi_oe_q, mosi_oe_d;
        logic             miso_oe_q, miso_oe_d;
        logic             ov_q, ov_d;
        logic [DW-1:0]    od_q, od_d;
        logic             sv_q, sv_d;
        logic [DW-1:0]    sd_q, sd_d;
        logic             push;
        logic [DW-1:0]    push_data;
        logic             in_ready;

        // two-flop synchronisers, plus one history stage on clock and select for edge finding
        always_ff @(posedge clk_in) begin
            if (srst_in) begin
                sck_s_q  <= 3'h0;
                sel_s_q  <= 3'h7;
                mosi_s_q <= 2'h0;
                miso_s_q <= 2'h0;
            end else begin
                sck_s_q  <= {sck_s_q[1:0], sck_in[c]};
                sel_s_q  <= {sel_s_q[1:0], ssel_n_in[c]};
                mosi_s_q <= {mosi_s_q[0], mosi_in[c]};
                miso_s_q <= {miso_s_q[0], miso_in[c]};
            end
        end

        // controller next state: sequencer, shifter, flags and drivers
        always_comb begin
            logic          selected;
            logic          sel_fall;
            logic          sel_rise;
            logic          sedge;
            logic          lead;
            logic          samp;
            logic          drv;
            logic          fin;
            logic          din;
            logic          wr_ok;
            logic [DW-1:0] rx_byte;
            selected  = ~sel_s_q[1];
            sel_fall  = sel_s_q[2] & ~sel_s_q[1];
            sel_rise  = ~sel_s_q[2] & sel_s_q[1];
            sedge     = sck_s_q[2] ^ sck_s_q[1];
            lead      = 1'b0;
            samp      = 1'b0;
            drv       = 1'b0;
            fin       = 1'b0;
            din       = 1'b0;
            wr_ok     = 1'b0;
            rx_byte   = RST_BYTE;
            push      = 1'b0;
            push_data = RST_BYTE;
            master_d  = master_q;
            mst_d     = mst_q;
            div_d     = div_q;
            ecnt_d    = ecnt_q;
            busy_d    = busy_q;
            sck_d     = sck_q;
            sh_d      = sh_q;
            dout_d    = dout_q;
            rbuf_d    = rbuf_q;
            done_d    = done_q;
            seen_d    = seen_q;
            win_d     = win_q;
            read_overrun_flag_d    = read_overrun_flag_q;
            write_collision_flag_d    = write_collision_flag_q;
            mode_fault_flag_d    = mode_fault_flag_q;
            slave_abort_flag_d    = slave_abort_flag_q;
            // status read arms the done clear, closes the write window
            if (status_rd_in[c]) begin
                read_overrun_flag_d = 1'b0;
                write_collision_flag_d = 1'b0;
                mode_fault_flag_d = 1'b0;
                slave_abort_flag_d = 1'b0;
                if (done_q) begin
                    seen_d = 1'b1;
                    win_d  = 1'b0;
                end
            end
            if ((data_rd_in[c] || data_wr_in[c]) && seen_q) begin
                done_d = 1'b0;
                seen_d = 1'b0;
            end
            // software enters master mode on a rising mode request
            if (!master_mode_in[c]) begin
                master_d = 1'b0;
            end else if (!mode_prev_q) begin
                master_d = 1'b1;
            end
            // data write goes straight to the shifter or collides
            if (data_wr_in[c]) begin
                if (win_q || busy_q || mst_q != SPIMSC_M_IDLE) begin
                    write_collision_flag_d = 1'b1;
                end else begin
                    wr_ok  = 1'b1;
                    sh_d   = data_wdata_in[c];
                    dout_d = data_wdata_in[c][DW-1];
                end
            end
            if (master_q) begin
                din = miso_s_q[1];
                case (mst_q)
                    SPIMSC_M_IDLE: begin
                        sck_d = cpol_in[c];
                        if (wr_ok) begin
                            win_d  = 1'b1;
                            div_d  = RST_DIV;
                            ecnt_d = 4'h0;
                            mst_d  = in_ready ? SPIMSC_M_RUN : SPIMSC_M_WAIT;
                        end
                    end
                    SPIMSC_M_WAIT: begin
                        if (in_ready) begin
                            mst_d = SPIMSC_M_RUN;
                        end
                    end
                    SPIMSC_M_RUN: begin
                        div_d = div_q + 8'h01;
                        if (div_d >= spimsc_half(clk_count_in[c])) begin
                            div_d  = RST_DIV;
                            sck_d  = ~sck_q;
                            lead   = ~ecnt_q[0];
                            samp   = lead ^ cpha_in[c];
                            drv    = ~samp;
                            ecnt_d = ecnt_q + 4'h1;
                            if (ecnt_q == LAST_EDGE) begin
                                fin   = 1'b1;
                                mst_d = SPIMSC_M_IDLE;
                            end
                        end
                    end
                    default: begin
                        mst_d = SPIMSC_M_IDLE;
                    end
                endcase
                // another master selected us
                if (selected) begin
                    mode_fault_flag_d   = 1'b1;
                    master_d = 1'b0;
                    mst_d    = SPIMSC_M_IDLE;
                    ecnt_d   = 4'h0;
                    sck_d    = cpol_in[c];
                    samp     = 1'b0;
                    drv      = 1'b0;
                    fin      = 1'b0;
                    win_d    = 1'b0;
                end
            end else begin
                din   = mosi_s_q[1];
                mst_d = SPIMSC_M_IDLE;
                sck_d = cpol_in[c];
                if (selected && sel_fall && !cpha_in[c]) begin
                    busy_d = 1'b1;
                    win_d  = 1'b1;
                    ecnt_d = 4'h0;
                end
                if (selected && sedge) begin
                    lead = sck_s_q[1] ^ cpol_in[c];
                    samp = lead ^ cpha_in[c];
                    drv  = ~samp;
                    if (cpha_in[c] && !busy_q) begin
                        busy_d = 1'b1;
                        win_d  = 1'b1;
                        ecnt_d = 4'h0;
                    end
                    if (samp) begin
                        ecnt_d = ecnt_q + 4'h1;
                        if (ecnt_q[2:0] == LAST_BIT) begin
                            fin    = 1'b1;
                            ecnt_d = 4'h0;
                            busy_d = ~cpha_in[c];
                        end
                    end
                end
                if (sel_rise && busy_q) begin
                    busy_d = 1'b0;
                    ecnt_d = 4'h0;
                    if (ecnt_q != 4'h0) begin
                        slave_abort_flag_d = 1'b1;
                        win_d  = 1'b0;
                        samp   = 1'b0;
                        drv    = 1'b0;
                        fin    = 1'b0;
                    end
                end
            end
            // sample on one edge kind, drive on the other
            rx_byte = {sh_q[DW-2:0], din};
            if (samp) begin
                sh_d = rx_byte;
            end
            if (drv) begin
                dout_d = sh_q[DW-1];
            end
            // completion: deliver byte unless unread or stream full
            if (fin) begin
                if (done_q || !in_ready) begin
                    read_overrun_flag_d = 1'b1;
                end else begin
                    // a phase 0 master ends on a drive edge: shifter already whole
                    rbuf_d    = samp ? rx_byte : sh_q;
                    done_d    = 1'b1;
                    seen_d    = 1'b0;
                    push      = 1'b1;
                    push_data = rbuf_d;
                end
            end
            // pad drivers: master owns clock and out, slave only when selected
            sck_oe_d  = master_d;
            mosi_oe_d = master_d;
            miso_oe_d = ~master_d & selected;
        end

        // two-entry receive stream buffer with registered output
        always_comb begin
            in_ready = ~sv_q;
            ov_d     = ov_q;
            od_d     = od_q;
            sv_d     = sv_q;
            sd_d     = sd_q;
            if (!ov_q || rx_ready_in[c]) begin
                if (sv_q) begin
                    ov_d = 1'b1;
                    od_d = sd_q;
                    sv_d = push;
                    sd_d = push ? push_data : sd_q;
                end else begin
                    ov_d = push;
                    od_d = push ? push_data : od_q;
                end
            end else if (push) begin
                sv_d = 1'b1;
                sd_d = push_data;
            end
        end

        // controller and buffer registers
        always_ff @(posedge clk_in) begin
            if (srst_in) begin
                master_q    <= 1'b0;
                mode_prev_q <= 1'b0;
                mst_q       <= SPIMSC_M_IDLE;
                div_q       <= RST_DIV;
                ecnt_q      <= 4'h0;
                busy_q      <= 1'b0;
                sck_q       <= 1'b0;
                sh_q        <= RST_BYTE;
                dout_q      <= 1'b0;
                rbuf_q      <= RST_BYTE;
                done_q      <= 1'b0;
                seen_q      <= 1'b0;
                win_q       <= 1'b0;
                read_overrun_flag_q      <= 1'b0;
                write_collision_flag_q      <= 1'b0;
                mode_fault_flag_q      <= 1'b0;
                slave_abort_flag_q      <= 1'b0;
                sck_oe_q    <= 1'b0;
                mosi_oe_q   <= 1'b0;
                miso_oe_q   <= 1'b0;
                ov_q        <= 1'b0;
                od_q        <= RST_BYTE;
                sv_q        <= 1'b0;
                sd_q        <= RST_BYTE;
            end else begin
                master_q    <= master_d;
                mode_prev_q <= master_mode_in[c];
                mst_q       <= mst_d;
                div_q       <= div_d;
                ecnt_q      <= ecnt_d;
                busy_q      <= busy_d;
                sck_q       <= sck_d;
                sh_q        <= sh_d;
                dout_q      <= dout_d;
                rbuf_q      <= rbuf_d;
                done_q      <= done_d;
                seen_q      <= seen_d;
                win_q       <= win_d;
                read_overrun_flag_q      <= read_overrun_flag_d;
                write_collision_flag_q      <= write_collision_flag_d;
                mode_fault_flag_q      <= mode_fault_flag_d;
                slave_abort_flag_q      <= slave_abort_flag_d;
                sck_oe_q    <= sck_oe_d;
                mosi_oe_q   <= mosi_oe_d;
                miso_oe_q   <= miso_oe_d;
                ov_q        <= ov_d;
                od_q        <= od_d;
                sv_q        <= sv_d;
                sd_q        <= sd_d;
            end
        end

        // outputs straight from flops
        assign rd_data_out[c]              = rbuf_q;
        assign transfer_done_flag_out[c]   = done_q;
        assign read_overrun_flag_out[c]    = read_overrun_flag_q;
        assign write_collision_flag_out[c] = write_collision_flag_q;
        assign mode_fault_flag_out[c]      = mode_fault_flag_q;
        assign slave_abort_flag_out[c]     = slave_abort_flag_q;
        assign is_master_out[c]            = master_q;
        assign rx_valid_out[c]             = ov_q;
        assign rx_data_out[c]              = od_q;
        assign sck_out[c]                  = sck_q;
        assign sck_oe_out[c]               = sck_oe_q;
        assign mosi_out[c]                 = dout_q;
        assign mosi_oe_out[c]              = mosi_oe_q;
        assign miso_out[c]                 = dout_q;
        assign miso_oe_out[c]              = miso_oe_q;
    end

endmodule

`default_nettype wire

// >>> verif/spimsc_checker.sv
`timescale 1ns/1ns
`default_nettype none
module spimsc_checker
    import spimsc_pkg::*;
(
    input wire logic                   clk_in,
    input wire logic                   srst_in,
    input wire logic [NCH-1:0]         cpol_in,
    input wire logic [NCH-1:0]         data_wr_in,
    input wire logic [NCH-1:0]         data_rd_in,
    input wire logic [NCH-1:0]         ssel_n_in,
    input wire logic [NCH-1:0][DW-1:0] rd_data_out,
    input wire logic [NCH-1:0]         transfer_done_flag_out,
    input wire logic [NCH-1:0]         read_overrun_flag_out,
    input wire logic [NCH-1:0]         write_collision_flag_out,
    input wire logic [NCH-1:0]         mode_fault_flag_out,
    input wire logic [NCH-1:0]         is_master_out,
    input wire logic [NCH-1:0]         sck_out,
    input wire logic [NCH-1:0]         sck_oe_out,
    input wire logic [NCH-1:0]         mosi_oe_out,
    input wire logic [NCH-1:0]         miso_oe_out
);
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (srst_in);
    // per-channel protocol properties, both channels alike
    for (genvar c = 0; c < NCH; c++) begin : g_ch
        AST_UNSEL_HIZ: assert property (
            (ssel_n_in[c] && !is_master_out[c])[*6] |-> !miso_oe_out[c])
            else $error("slave out driven while not selected");
        AST_SEL_DRIVE: assert property (
            (!ssel_n_in[c] && !is_master_out[c])[*6] |-> miso_oe_out[c])
            else $error("selected slave not driving");
        AST_DONE_CLR: assert property (
            $fell(transfer_done_flag_out[c]) |-> $past(data_rd_in[c] || data_wr_in[c]))
            else $error("done flag cleared without data access");
        AST_DONE_HOLD: assert property (
            transfer_done_flag_out[c] && !data_rd_in[c] && !data_wr_in[c]
            |=> transfer_done_flag_out[c])
            else $error("done flag dropped by itself");
        AST_WRITE_COLLISION_FLAG_CAUSE: assert property (
            $rose(write_collision_flag_out[c]) |-> $past(data_wr_in[c]))
            else $error("collision without a data write");
        AST_OVR_KEEP: assert property (
            $rose(read_overrun_flag_out[c]) |-> $stable(rd_data_out[c]))
            else $error("receive buffer replaced on overrun");
        AST_MODE_FAULT_FLAG_CAUSE: assert property (
            $rose(mode_fault_flag_out[c]) |-> $past(is_master_out[c]))
            else $error("mode fault while slave");
        AST_MODE_FAULT_FLAG_OFF: assert property (
            $rose(mode_fault_flag_out[c])
            |-> ##[0:2] (!is_master_out[c] && !sck_oe_out[c] && !mosi_oe_out[c]))
            else $error("master drivers left on after mode fault");
        AST_SCK_RATE: assert property (
            sck_oe_out[c] && $changed(sck_out[c]) |=> $stable(sck_out[c])[*3])
            else $error("serial clock half period below four cycles");
        AST_END_IDLE: assert property (
            $rose(transfer_done_flag_out[c]) && is_master_out[c] |-> sck_out[c] == cpol_in[c])
            else $error("master transfer ended with clock not idle");
    end
endmodule
bind spimsc_top spimsc_checker spimsc_checker_inst (.*);
`default_nettype wire

// >>> verif/spimsc_peer.sv
`timescale 1ns/1ns
`default_nettype none
module spimsc_peer (
    input  wire logic cpol_in,
    input  wire logic cpha_in,
    input  wire logic sck_in,
    input  wire logic mosi_in,
    input  wire logic miso_in,
    output logic      sck_out,
    output logic      mosi_out,
    output logic      miso_out,
    output logic      ssel_n_out
);
    logic [7:0] ssh, srx, mrx;
    logic       mdrv, mbit, obit, fill;
    // released lines show a pattern that changes every few ns
    initial begin
        {mdrv, mbit, obit, fill, sck_out, ssh} = '0;
        ssel_n_out = 1'b1;
        forever #7 fill = ~fill;
    end
    assign mosi_out = mdrv ? mbit : fill;
    assign miso_out = mdrv ? fill : obit;
    // slave role: drive and sample per polarity and phase
    always @(sck_in) if (!mdrv) begin
        if (sck_in != cpol_in) begin
            if (cpha_in) begin obit = ssh[7]; ssh = ssh << 1; end
            else srx = {srx[6:0], mosi_in};
        end else begin
            if (cpha_in) srx = {srx[6:0], mosi_in};
            else begin ssh = ssh << 1; obit = ssh[7]; end
        end
    end
    // first bit is on the line before the first clock edge
    task automatic load(input logic [7:0] b);
        ssh = b;
        obit = b[7];
    endtask
    // master role: n bits at 80 ns per bit, select released after
    task automatic xfer(input logic [7:0] tx, input int n);
        logic [7:0] sh;
        sh = tx;
        sck_out = cpol_in;
        #40 mdrv = 1'b1;
        ssel_n_out = 1'b0;
        mbit = sh[7];
        #120;
        for (int i = 0; i < n; i++) begin
            #40 sck_out = ~cpol_in;
            if (cpha_in) begin mbit = sh[7]; sh = sh << 1; end
            else mrx = {mrx[6:0], miso_in};
            #40 if (cpha_in) mrx = {mrx[6:0], miso_in};
            else begin sh = sh << 1; mbit = sh[7]; end
            sck_out = cpol_in;
        end
        #120 ssel_n_out = 1'b1;
        mdrv = 1'b0;
    endtask
endmodule
`default_nettype wire

// >>> verif/spimsc_top_tb.sv
`timescale 1ns/1ns
`default_nettype none
`define CHK(n, e, a) begin check_count++; if ((a) !== (e)) begin failures++; \
    $display("CHECK FAILED %s exp %0h got %0h", n, e, a); end end
module spimsc_top_tb;
    import spimsc_pkg::*;
    logic                      clk_in, srst_in;
    logic [NCH-1:0]            master_mode_in, cpol_in, cpha_in, data_wr_in, data_rd_in;
    logic [NCH-1:0]            status_rd_in, rx_ready_in, rx_valid_out, is_master_out;
    logic [NCH-1:0][CNT_W-1:0] clk_count_in;
    logic [NCH-1:0][DW-1:0]    data_wdata_in, rd_data_out, rx_data_out;
    logic [NCH-1:0]            transfer_done_flag_out, read_overrun_flag_out;
    logic [NCH-1:0]            write_collision_flag_out, mode_fault_flag_out;
    logic [NCH-1:0]            slave_abort_flag_out, sck_out, sck_oe_out, mosi_out;
    logic [NCH-1:0]            mosi_oe_out, miso_out, miso_oe_out;
    wire  logic [NCH-1:0]      sck_in, ssel_n_in, mosi_in, miso_in, p_sck, p_mosi, p_miso;
    int                        failures, check_count;

    spimsc_top spimsc_top_inst (.*);
    // one far-side device per channel; pins resolved from the enables
    for (genvar c = 0; c < NCH; c++) begin : g_peer
        spimsc_peer spimsc_peer_inst (.cpol_in(cpol_in[c]), .cpha_in(cpha_in[c]),
            .sck_in(sck_in[c]), .mosi_in(mosi_in[c]), .miso_in(miso_in[c]),
            .sck_out(p_sck[c]), .mosi_out(p_mosi[c]), .miso_out(p_miso[c]),
            .ssel_n_out(ssel_n_in[c]));
        assign sck_in[c]  = sck_oe_out[c] ? sck_out[c] : p_sck[c];
        assign mosi_in[c] = mosi_oe_out[c] ? mosi_out[c] : p_mosi[c];
        assign miso_in[c] = miso_oe_out[c] ? miso_out[c] : p_miso[c];
    end

    initial begin
        clk_in = 1'b0;
        forever #5 clk_in = ~clk_in;
    end
    // hang guard
    initial begin
        repeat (20000) @(posedge clk_in);
        failures++;
        wrap_up();
    end

    task automatic wrap_up();
        if (failures == 0 && check_count > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    // k: 0 data write, 1 data read, 2 status read
    task automatic pulse(input int c, input int k);
        @(negedge clk_in);
        if (k == 0) data_wr_in[c] = 1'b1;
        else if (k == 1) data_rd_in[c] = 1'b1;
        else status_rd_in[c] = 1'b1;
        @(negedge clk_in);
        {data_wr_in[c], data_rd_in[c], status_rd_in[c]} = 3'h0;
        @(negedge clk_in);
    endtask
    task automatic wait_done(input int c, output int n);
        n = 0;
        while (transfer_done_flag_out[c] !== 1'b1 && n < 3000) begin
            @(negedge clk_in);
            n++;
        end
    endtask
    function automatic int bit_cyc(input logic [7:0] cnt);
        return ((cnt < 8) ? 8 : int'(cnt)) & ~1;
    endfunction

    initial begin
        int n, p;
        logic [7:0] mb, sb, bq[2];
        {master_mode_in, cpol_in, cpha_in, data_wr_in, data_rd_in, status_rd_in} = '0;
        {clk_count_in, data_wdata_in} = '0;
        rx_ready_in = 2'b11;
        srst_in = 1'b1;
        n = $urandom(42061);
        repeat (3) @(negedge clk_in);
        srst_in = 1'b0;
        master_mode_in[0] = 1'b1;
        repeat (3) @(negedge clk_in);
        // channel 0 as master, all four formats, random and floor rates
        for (int m = 0; m < 4; m++) begin
            {cpol_in[0], cpha_in[0]} = 2'(m);
            repeat (2) @(negedge clk_in); // idle clock level settles before the peer loads
            clk_count_in[0] = (m == 0) ? 8'h00 : 8'(8 + $urandom_range(0, 12));
            mb = 8'($urandom);
            sb = 8'($urandom);
            g_peer[0].spimsc_peer_inst.load(sb);
            data_wdata_in[0] = mb;
            pulse(0, 0);
            if (m == 2) begin
                data_wdata_in[0] = ~mb;
                pulse(0, 0);
            end
            wait_done(0, n);
            p = bit_cyc(clk_count_in[0]);
            `CHK("mst_tx", mb, g_peer[0].spimsc_peer_inst.srx)
            `CHK("mst_rx", sb, rd_data_out[0])
            `CHK("mst_stream", sb, rx_data_out[0])
            `CHK("mst_rate", 1'b1, n >= 8 * p - 6 && n <= 8 * p + 8)
            if (m == 2) `CHK("write_collision_flag", 1'b1, write_collision_flag_out[0])
            pulse(0, 2);
            `CHK("done_kept", 1'b1, transfer_done_flag_out[0])
            pulse(0, 1);
            `CHK("done_clr", 1'b0, transfer_done_flag_out[0])
        end
        // select pulled low while master
        g_peer[0].spimsc_peer_inst.xfer(8'h00, 0);
        `CHK("mode_fault_flag", 3'b100, {mode_fault_flag_out[0], is_master_out[0], sck_oe_out[0]})
        // channel 1 as slave, all four formats
        for (int m = 0; m < 4; m++) begin
            {cpol_in[1], cpha_in[1]} = 2'(m);
            clk_count_in[1] = 8'($urandom);
            sb = 8'($urandom);
            mb = 8'($urandom);
            data_wdata_in[1] = sb;
            pulse(1, 0);
            g_peer[1].spimsc_peer_inst.xfer(mb, 8);
            repeat (6) @(negedge clk_in);
            `CHK("slv_rx", mb, rd_data_out[1])
            `CHK("slv_tx", sb, g_peer[1].spimsc_peer_inst.mrx)
            pulse(1, 2);
            pulse(1, 1);
        end
        // completion with done still set loses the byte
        g_peer[1].spimsc_peer_inst.xfer(mb, 8);
        g_peer[1].spimsc_peer_inst.xfer(~mb, 8);
        `CHK("ovr", 2'b11, {read_overrun_flag_out[1], rd_data_out[1] === mb})
        pulse(1, 2);
        pulse(1, 1);
        // select released after four bits, then a clean byte
        g_peer[1].spimsc_peer_inst.xfer(8'h5A, 4);
        repeat (6) @(negedge clk_in); // select release passes the synchroniser
        `CHK("abort", 2'b10, {slave_abort_flag_out[1], transfer_done_flag_out[1]})
        g_peer[1].spimsc_peer_inst.xfer(8'hC3, 8);
        repeat (6) @(negedge clk_in);
        `CHK("after_abort", 8'hC3, rd_data_out[1])
        pulse(1, 2);
        pulse(1, 1);
        // stalled receiver: two entries held, third completion refused
        rx_ready_in[1] = 1'b0;
        for (int i = 0; i < 3; i++) begin
            mb = 8'($urandom);
            if (i < 2) bq[i] = mb;
            g_peer[1].spimsc_peer_inst.xfer(mb, 8);
            repeat (6) @(negedge clk_in);
            if (i == 2) `CHK("full_ovr", 1'b1, read_overrun_flag_out[1])
            pulse(1, 2);
            pulse(1, 1);
        end
        for (int i = 0; i < 2; i++) begin
            `CHK("drain", {1'b1, bq[i]}, {rx_valid_out[1], rx_data_out[1]})
            rx_ready_in[1] = 1'b1;
            @(negedge clk_in);
            rx_ready_in[1] = 1'b0;
        end
        `CHK("empty", 1'b0, rx_valid_out[1])
        wrap_up();
    end
endmodule
`default_nettype wire
